//--- far_reporter.sv
// Fault alarm and error reporter: maps detected conditions to error codes,
// halt and alarm decisions. Condition inputs are one-cycle event pulses
// from test, correction, parser and interlock logic on the same clock.
`timescale 1ns/1ps
// What this block does
// [RULE_01] Flag range exceeded while measurement leaves measurable range.
// [RULE_02] Flag over-current while current limit reduces source output.
// [RULE_03] Conversion failure gives code 11, halts and raises alarm.
// [RULE_04] ROM fault 12: power-on halts with alarm; self-test runs with alarm.
// [RULE_05] RAM fault 13 or memory test fault 14 halts with alarm.
// [RULE_06] User data lost 15: power-on loads defaults, no alarm; self-test alarms.
// [RULE_07] Settings lost 16: power-on runs quietly; self-test halts with alarm.
// [RULE_08] Save failure gives 17 without alarm; memory fault gives 14.
// [RULE_09] Recall empty gives 18 without alarm; memory fault gives 14.
// [RULE_10] Printer silent gives 19, operation continues, no alarm.
// [RULE_11] Board fault 20: power-on halts with alarm; self-test runs with alarm.
// [RULE_12] Handler lockout blocks panel keys and re-enable; code 21, no alarm.
// [RULE_13] Open correction leakage at or beyond 11 uA gives code 32.
// [RULE_14] Leakage between about 10 pA and 10 uA gives only a warning.
// [RULE_15] Open correction stray capacitance of 75 pF or more gives 33.
// [RULE_16] Unknown fixture gives 35; nothing attached or cover open gives 36.
// [RULE_17] Header mnemonic over twelve characters gives -112.
// [RULE_18] Character data over twelve characters gives -144.
// [RULE_19] Exponent over 32000 gives -123; over 255 digits gives -124.
// [RULE_20] Trigger inside a program message gives -105.
// [RULE_21] Too many parameters gives -108; too few gives -109.
// [RULE_22] Generic -100 only when no specific syntax code applies.
module far_reporter (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire far_pkg::far_phase_t phase,
    input  wire logic               meas_out_of_range,
    input  wire logic               current_limited,
    input  wire logic               adc_fail,
    input  wire logic               rom_fail,
    input  wire logic               ram_fail,
    input  wire logic               nvm_fail,
    input  wire logic               user_data_lost,
    input  wire logic               prev_set_lost,
    input  wire logic               save_fail,
    input  wire logic               recall_empty,
    input  wire logic               nvm_fault_cause,
    input  wire logic               printer_silent,
    input  wire logic               board_fail,
    input  wire logic               handler_lockout,
    input  wire logic               panel_key,
    input  wire logic               unlock_req,
    input  wire logic               open_corr_done,
    input  wire logic signed [31:0] leak_pa,
    input  wire logic        [31:0] stray_ff,
    input  wire logic               fixture_unknown,
    input  wire logic               interlock_open,
    input  wire logic               parse_err,
    input  wire logic        [7:0]  mnem_len,
    input  wire logic        [7:0]  chr_len,
    input  wire logic        [15:0] exp_mag,
    input  wire logic        [8:0]  mant_digits,
    input  wire logic               get_in_msg,
    input  wire logic               par_more,
    input  wire logic               par_less,
    input  wire logic               clear_code,
    output logic                    range_exceeded_flag_q,
    output logic                    over_current_q,
    output logic                    leak_warn_q,
    output logic                    halt_q,
    output logic                    alarm_q,
    output logic                    load_defaults_q,
    output logic                    key_q,
    output logic                    keys_enabled_q,
    output logic             [15:0] err_code_q,
    output logic                    err_valid_q
);
    logic po;
    logic st;
    assign po = (phase == far_pkg::FAR_PH_POWER_ON);
    assign st = (phase == far_pkg::FAR_PH_SELF);

    // Instrument faults: priority ordered, halting faults first
    logic nvm_path;
    assign nvm_path = (save_fail | recall_empty) & nvm_fault_cause;

    logic [15:0] inst_code;
    logic        inst_hit;
    logic        inst_halt;
    logic        inst_alarm;
    assign inst_hit = adc_fail | rom_fail | ram_fail | nvm_fail | nvm_path
                    | user_data_lost | prev_set_lost | save_fail
                    | recall_empty | printer_silent | board_fail;
    assign inst_code =
        adc_fail                ? far_pkg::FAR_E_ADC     : // RULE_03
        ram_fail                ? far_pkg::FAR_E_RAM     : // RULE_05
        (nvm_fail | nvm_path)   ? far_pkg::FAR_E_NVM     : // RULE_08
        rom_fail                ? far_pkg::FAR_E_ROM     : // RULE_04
        board_fail              ? far_pkg::FAR_E_BOARD   : // RULE_11
        prev_set_lost           ? far_pkg::FAR_E_PREV    : // RULE_07
        user_data_lost          ? far_pkg::FAR_E_USER    : // RULE_06
        save_fail               ? far_pkg::FAR_E_SAVE    : // RULE_08
        recall_empty            ? far_pkg::FAR_E_RECALL  : // RULE_09
                                  far_pkg::FAR_E_PRINTER;  // RULE_10
    assign inst_halt = adc_fail | ram_fail | nvm_fail | nvm_path
                     | ((rom_fail | board_fail) & po)
                     | (prev_set_lost & st);
    assign inst_alarm = adc_fail | ram_fail | nvm_fail | nvm_path
                      | ((rom_fail | board_fail) & (po | st))
                      | (user_data_lost & st)
                      | (prev_set_lost & st);

    // Correction and fixture conditions
    logic leak_err;
    logic leak_mid;
    logic stray_err;
    assign leak_err = open_corr_done
        & ((leak_pa >= far_pkg::FAR_LEAK_ERR_PA)
         | (leak_pa <= -far_pkg::FAR_LEAK_ERR_PA));             // RULE_13
    assign leak_mid = open_corr_done & ~leak_err
        & (((leak_pa > far_pkg::FAR_LEAK_WARN_LO)
          & (leak_pa < far_pkg::FAR_LEAK_WARN_HI))
         | ((leak_pa < -far_pkg::FAR_LEAK_WARN_LO)
          & (leak_pa > -far_pkg::FAR_LEAK_WARN_HI)));           // RULE_14
    assign stray_err = open_corr_done
        & (stray_ff >= far_pkg::FAR_STRAY_ERR_FF);              // RULE_15

    // Lockout: panel keys refused, attempt to re-enable reported
    logic lock_hit;
    assign lock_hit = handler_lockout & (panel_key | unlock_req); // RULE_12

    // Parser: specific codes first, -100 only as fallback
    logic [15:0] syn_code;
    logic        syn_hit;
    assign syn_hit = parse_err | get_in_msg | par_more | par_less;
    assign syn_code =
        get_in_msg                       ? far_pkg::FAR_E_GET      : // RULE_20
        (mnem_len > far_pkg::FAR_MNEM_MAX) ? far_pkg::FAR_E_HDR_LONG : // RULE_17
        (chr_len > far_pkg::FAR_MNEM_MAX)  ? far_pkg::FAR_E_CHR_LONG : // RULE_18
        (exp_mag > far_pkg::FAR_EXP_MAX)   ? far_pkg::FAR_E_EXP_BIG  : // RULE_19
        (mant_digits > far_pkg::FAR_DIGITS_MAX)
                                         ? far_pkg::FAR_E_DIGITS   : // RULE_19
        par_more                         ? far_pkg::FAR_E_PAR_MORE : // RULE_21
        par_less                         ? far_pkg::FAR_E_PAR_LESS : // RULE_21
                                           far_pkg::FAR_E_CMD;       // RULE_22

    // Final code selection
    logic        any_hit;
    logic [15:0] next_code;
    assign any_hit = inst_hit | leak_err | stray_err | fixture_unknown
                   | interlock_open | lock_hit | syn_hit;
    assign next_code =
        inst_hit        ? inst_code                : 
        leak_err        ? far_pkg::FAR_E_LEAK      : // RULE_13
        stray_err       ? far_pkg::FAR_E_STRAY     : // RULE_15
        fixture_unknown ? far_pkg::FAR_E_FIXTURE   : // RULE_16
        interlock_open  ? far_pkg::FAR_E_INTLK     : // RULE_16
        lock_hit        ? far_pkg::FAR_E_LOCKOUT   : // RULE_12
                          syn_code;

    far_code_reg u_code (
        .clk        (clk),
        .rst        (rst),
        .load       (any_hit),
        .code_in    (next_code),
        .clear_code (clear_code),
        .code_q     (err_code_q),
        .valid_q    (err_valid_q)
    );

    // Halt and alarm are sticky until reset; a clear cannot stop a fault
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halt_q  <= 1'b0;
            alarm_q <= 1'b0;
        end else begin
            halt_q  <= halt_q | (inst_hit & inst_halt);   // RULE_05
            alarm_q <= alarm_q | (inst_hit & inst_alarm); // RULE_03
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            range_exceeded_flag_q <= 1'b0;
            over_current_q        <= 1'b0;
            leak_warn_q           <= 1'b0;
            load_defaults_q       <= 1'b0;
            key_q                 <= 1'b0;
            keys_enabled_q        <= 1'b1;
        end else begin
            range_exceeded_flag_q <= meas_out_of_range;     // RULE_01
            over_current_q        <= current_limited;       // RULE_02
            leak_warn_q           <= leak_mid;              // RULE_14
            load_defaults_q       <= user_data_lost & po;   // RULE_06
            key_q                 <= panel_key & ~handler_lockout; // RULE_12
            keys_enabled_q        <= ~handler_lockout;      // RULE_12
        end
    end

    // Check helpers: louder faults that would mask the one under test
    logic hard_ev;
    logic front_hit;
    logic sizes_ok;
    logic calm;
    assign hard_ev   = adc_fail | ram_fail | nvm_fail | nvm_path
                     | rom_fail | board_fail;
    assign front_hit = inst_hit | leak_err | stray_err | fixture_unknown
                     | interlock_open | lock_hit;
    assign sizes_ok  = (mnem_len <= far_pkg::FAR_MNEM_MAX)
                     & (chr_len <= far_pkg::FAR_MNEM_MAX)
                     & (exp_mag <= far_pkg::FAR_EXP_MAX)
                     & (mant_digits <= far_pkg::FAR_DIGITS_MAX);
    assign calm      = ~hard_ev & ~prev_set_lost & ~user_data_lost
                     & ~halt_q & ~alarm_q;

    // A halting fault must stay halted, not just blink
    sequence held_s;
        halt_q && alarm_q ##1 halt_q && alarm_q;
    endsequence
    sequence quiet_s;
        !halt_q && !alarm_q;
    endsequence

    // Checks
    halt_adc_a: assert property (@(posedge clk) disable iff (rst) // RULE_03
        adc_fail |=> halt_q && alarm_q)
        else $error("adc failure did not halt with alarm");
    rom_self_a: assert property (@(posedge clk) disable iff (rst) // RULE_04
        rom_fail && st && !halt_q && !adc_fail && !ram_fail && !nvm_fail
        && !nvm_path && !prev_set_lost |=> !halt_q && alarm_q)
        else $error("rom self-test fault handled wrongly");
    ram_halt_a: assert property (@(posedge clk) disable iff (rst) // RULE_05
        (ram_fail || nvm_fail) |=> halt_q ##1 halt_q)
        else $error("memory fault did not halt");
    user_po_a: assert property (@(posedge clk) disable iff (rst) // RULE_06
        user_data_lost && po |=> load_defaults_q)
        else $error("defaults not loaded");
    save_code_a: assert property (@(posedge clk) disable iff (rst) // RULE_08
        save_fail && nvm_fault_cause && !adc_fail && !ram_fail
        |=> err_code_q == far_pkg::FAR_E_NVM)
        else $error("memory save fault not reported as 14");
    lock_keys_a: assert property (@(posedge clk) disable iff (rst) // RULE_12
        handler_lockout |=> !key_q && !keys_enabled_q)
        else $error("panel key passed during lockout");
    hdr_long_a: assert property (@(posedge clk) disable iff (rst) // RULE_17
        parse_err && !inst_hit && !leak_err && !stray_err
        && !fixture_unknown && !interlock_open && !lock_hit && !get_in_msg
        && mnem_len > far_pkg::FAR_MNEM_MAX
        |=> err_code_q == far_pkg::FAR_E_HDR_LONG)
        else $error("long header not reported");
    range_flag_a: assert property (@(posedge clk) disable iff (rst) // RULE_01
        meas_out_of_range |=> range_exceeded_flag_q)
        else $error("range flag missing");
    stray_code_a: assert property (@(posedge clk) disable iff (rst) // RULE_15
        stray_err && !inst_hit && !leak_err
        |=> err_code_q == far_pkg::FAR_E_STRAY)
        else $error("stray capacitance code missing");
    over_cur_a: assert property (@(posedge clk) disable iff (rst) // RULE_02
        current_limited |=> over_current_q)
        else $error("over-current flag missing");
    adc_hold_a: assert property (@(posedge clk) disable iff (rst) // RULE_03
        adc_fail |=> held_s)
        else $error("adc halt not held");
    rom_po_a: assert property (@(posedge clk) disable iff (rst) // RULE_04
        rom_fail && po |=> held_s)
        else $error("rom power-on fault did not halt");
    user_st_a: assert property (@(posedge clk) disable iff (rst) // RULE_06
        user_data_lost && st && !hard_ev && !prev_set_lost && !halt_q
        |=> !halt_q && alarm_q)
        else $error("user data loss in self-test handled wrongly");
    prev_po_a: assert property (@(posedge clk) disable iff (rst) // RULE_07
        prev_set_lost && po && !hard_ev && !halt_q && !alarm_q
        |=> quiet_s)
        else $error("settings loss at power-on raised alarm");
    prev_st_a: assert property (@(posedge clk) disable iff (rst) // RULE_07
        prev_set_lost && st |=> held_s)
        else $error("settings loss in self-test did not halt");
    save_quiet_a: assert property (@(posedge clk) disable iff (rst) // RULE_08
        save_fail && !nvm_fault_cause && calm
        |=> !halt_q && !alarm_q && err_code_q == far_pkg::FAR_E_SAVE)
        else $error("save failure handled wrongly");
    recall_code_a: assert property (@(posedge clk) disable iff (rst) // RULE_09
        recall_empty && !nvm_fault_cause && calm && !save_fail
        |=> err_code_q == far_pkg::FAR_E_RECALL && !alarm_q)
        else $error("recall failure handled wrongly");
    printer_a: assert property (@(posedge clk) disable iff (rst) // RULE_10
        printer_silent && calm && !save_fail && !recall_empty
        |=> err_code_q == far_pkg::FAR_E_PRINTER && !alarm_q)
        else $error("printer fault handled wrongly");
    lock_code_a: assert property (@(posedge clk) disable iff (rst) // RULE_12
        handler_lockout && panel_key && !inst_hit && !open_corr_done
        && !fixture_unknown && !interlock_open && !alarm_q
        |=> err_code_q == far_pkg::FAR_E_LOCKOUT && !alarm_q)
        else $error("lockout key press handled wrongly");
    leak_code_a: assert property (@(posedge clk) disable iff (rst) // RULE_13
        open_corr_done && !inst_hit
        && (leak_pa >= far_pkg::FAR_LEAK_ERR_PA
         || leak_pa <= -far_pkg::FAR_LEAK_ERR_PA)
        |=> err_code_q == far_pkg::FAR_E_LEAK)
        else $error("high leakage code missing");
    chr_long_a: assert property (@(posedge clk) disable iff (rst) // RULE_18
        parse_err && !front_hit && !get_in_msg
        && mnem_len <= far_pkg::FAR_MNEM_MAX
        && chr_len > far_pkg::FAR_MNEM_MAX
        |=> err_code_q == far_pkg::FAR_E_CHR_LONG)
        else $error("long character data not reported");
    get_code_a: assert property (@(posedge clk) disable iff (rst) // RULE_20
        get_in_msg && !front_hit |=> err_code_q == far_pkg::FAR_E_GET)
        else $error("trigger in message not reported");
    par_more_a: assert property (@(posedge clk) disable iff (rst) // RULE_21
        par_more && !front_hit && !get_in_msg && sizes_ok
        |=> err_code_q == far_pkg::FAR_E_PAR_MORE)
        else $error("extra parameter not reported");
    cmd_code_a: assert property (@(posedge clk) disable iff (rst) // RULE_22
        parse_err && !front_hit && !get_in_msg && !par_more && !par_less
        && sizes_ok |=> err_code_q == far_pkg::FAR_E_CMD)
        else $error("generic command error not reported");
endmodule : far_reporter

//--- far_pkg.sv
// Package for the fault alarm and error reporter: error codes, test phases,
// and thresholds. Used by far_reporter and the testbench.
package far_pkg;

    typedef enum logic [1:0] {
        FAR_PH_RUN      = 2'b00,
        FAR_PH_POWER_ON = 2'b01,
        FAR_PH_SELF     = 2'b10
    } far_phase_t;

    // Error codes as signed 16-bit numbers shown or sent over the bus
    localparam logic signed [15:0] FAR_E_NONE     = 16'sh0000;
    localparam logic signed [15:0] FAR_E_ADC      = 16'sh000b;
    localparam logic signed [15:0] FAR_E_ROM      = 16'sh000c;
    localparam logic signed [15:0] FAR_E_RAM      = 16'sh000d;
    localparam logic signed [15:0] FAR_E_NVM      = 16'sh000e;
    localparam logic signed [15:0] FAR_E_USER     = 16'sh000f;
    localparam logic signed [15:0] FAR_E_PREV     = 16'sh0010;
    localparam logic signed [15:0] FAR_E_SAVE     = 16'sh0011;
    localparam logic signed [15:0] FAR_E_RECALL   = 16'sh0012;
    localparam logic signed [15:0] FAR_E_PRINTER  = 16'sh0013;
    localparam logic signed [15:0] FAR_E_BOARD    = 16'sh0014;
    localparam logic signed [15:0] FAR_E_LOCKOUT  = 16'sh0015;
    localparam logic signed [15:0] FAR_E_LEAK     = 16'sh0020;
    localparam logic signed [15:0] FAR_E_STRAY    = 16'sh0021;
    localparam logic signed [15:0] FAR_E_FIXTURE  = 16'sh0023;
    localparam logic signed [15:0] FAR_E_INTLK    = 16'sh0024;
    localparam logic signed [15:0] FAR_E_CMD      = -16'sh0064;
    localparam logic signed [15:0] FAR_E_GET      = -16'sh0069;
    localparam logic signed [15:0] FAR_E_PAR_MORE = -16'sh006c;
    localparam logic signed [15:0] FAR_E_PAR_LESS = -16'sh006d;
    localparam logic signed [15:0] FAR_E_HDR_LONG = -16'sh0070;
    localparam logic signed [15:0] FAR_E_EXP_BIG  = -16'sh007b;
    localparam logic signed [15:0] FAR_E_DIGITS   = -16'sh007c;
    localparam logic signed [15:0] FAR_E_CHR_LONG = -16'sh0090;

    // Leakage in pA, signed 32-bit; capacitance in fF, unsigned 32-bit
    localparam logic signed [31:0] FAR_LEAK_ERR_PA  = 32'sh00a7d8c0; // 11 uA
    localparam logic signed [31:0] FAR_LEAK_WARN_HI = 32'sh00989680; // 10 uA
    localparam logic signed [31:0] FAR_LEAK_WARN_LO = 32'sh0000000a; // 10 pA
    localparam logic        [31:0] FAR_STRAY_ERR_FF = 32'h000124f8;  // 75 pF

    localparam logic [7:0]  FAR_MNEM_MAX     = 8'h0c;
    localparam logic [15:0] FAR_EXP_MAX      = 16'h7d00;
    localparam logic [8:0]  FAR_DIGITS_MAX   = 9'h0ff;

endpackage : far_pkg

//--- far_code_reg.sv
// Holds the most recent error code and its valid flag.
// Assumes a single clock; sticky until clear_code or reset.
`timescale 1ns/1ps
module far_code_reg (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire logic [15:0] code_in,
    input  wire logic        clear_code,
    output logic      [15:0] code_q,
    output logic             valid_q
);
    // Load wins over clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            code_q  <= 16'h0000;
            valid_q <= 1'b0;
        end else if (load) begin
            code_q  <= code_in;
            valid_q <= 1'b1;
        end else if (clear_code) begin
            code_q  <= 16'h0000;
            valid_q <= 1'b0;
        end
    end
endmodule : far_code_reg

//--- far_hs_model.sv
// Handler and bus controller stand-in for the fault reporter.
// Assumes bench commands arrive on clk; all outputs are registered.
`timescale 1ns/1ps
module far_hs_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic lock_cmd,
    input  wire logic press_cmd,
    input  wire logic unlock_cmd,
    output logic      handler_lockout,
    output logic      panel_key,
    output logic      unlock_req
);
    // Registered, so key and re-enable pulses lag the command by a cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            handler_lockout <= 1'b0;
            panel_key       <= 1'b0;
            unlock_req      <= 1'b0;
        end else begin
            handler_lockout <= lock_cmd;
            panel_key       <= press_cmd;
            unlock_req      <= unlock_cmd;
        end
    end
endmodule : far_hs_model

//--- testbench.sv
// Self-checking bench for far_reporter with the handler model.
// Assumes far_pkg compiled first; each case starts from a fresh reset.
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [15:0] code;
        logic [7:0]  flg; // vld hlt alm ld wrn key ke msk
    } far_note_t;
    localparam far_pkg::far_phase_t RUN = far_pkg::FAR_PH_RUN;
    localparam far_pkg::far_phase_t PON = far_pkg::FAR_PH_POWER_ON;
    localparam far_pkg::far_phase_t SLF = far_pkg::FAR_PH_SELF;
    localparam logic [7:0] F_HA = 8'he2, F_A = 8'ha2, F_N = 8'h82;
    localparam logic [7:0] F_LD = 8'h92, F_C = 8'he2, F_W = 8'h0a;
    logic clk = 0, rst = 1, meas = 0, clim = 0, cause = 0;
    logic lock_cmd = 0, press_cmd = 0, unl_cmd = 0, took = 0, clr = 0;
    far_pkg::far_phase_t phase = RUN;
    logic [16:0] ev_v = '0;
    logic signed [31:0] leak = 0;
    logic [31:0] stray = 0;
    logic [7:0] mlen = 0, clen = 0;
    logic [15:0] emag = 0, ecq;
    logic [8:0] mdig = 0;
    logic lockout, pkey, unlock, rof, ocq, lwq, hq, aq, ldq, kq, keq, evq;
    far_note_t notes[$];
    far_note_t n;
    logic [7:0] m, rl;
    int fails = 0;
    int compares = 0;

    far_hs_model hs_u (.clk(clk), .rst(rst), .lock_cmd(lock_cmd),
        .press_cmd(press_cmd), .unlock_cmd(unl_cmd),
        .handler_lockout(lockout), .panel_key(pkey), .unlock_req(unlock));
    far_reporter dut_u (.clk(clk), .rst(rst), .phase(phase),
        .meas_out_of_range(meas), .current_limited(clim),
        .adc_fail(ev_v[0]), .rom_fail(ev_v[1]), .ram_fail(ev_v[2]),
        .nvm_fail(ev_v[3]), .user_data_lost(ev_v[4]),
        .prev_set_lost(ev_v[5]), .save_fail(ev_v[6]),
        .recall_empty(ev_v[7]), .nvm_fault_cause(cause),
        .printer_silent(ev_v[8]), .board_fail(ev_v[9]),
        .handler_lockout(lockout), .panel_key(pkey), .unlock_req(unlock),
        .open_corr_done(ev_v[10]), .leak_pa(leak), .stray_ff(stray),
        .fixture_unknown(ev_v[11]), .interlock_open(ev_v[12]),
        .parse_err(ev_v[13]), .mnem_len(mlen), .chr_len(clen),
        .exp_mag(emag), .mant_digits(mdig), .get_in_msg(ev_v[14]),
        .par_more(ev_v[15]), .par_less(ev_v[16]), .clear_code(clr),
        .range_exceeded_flag_q(rof), .over_current_q(ocq),
        .leak_warn_q(lwq), .halt_q(hq), .alarm_q(aq), .load_defaults_q(ldq),
        .key_q(kq), .keys_enabled_q(keq), .err_code_q(ecq),
        .err_valid_q(evq));

    always #20 clk = ~clk;

    function automatic logic [16:0] ev(input int k);
        return 17'h1 << k;
    endfunction : ev

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] s);
        compares++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic wrap_up();
        $display("Counts: compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    task automatic rst_dut();
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
    endtask : rst_dut

    task automatic fire(input far_pkg::far_phase_t ph, input logic [16:0] e,
                        input logic [15:0] c, input logic [7:0] f);
        rst_dut();
        phase <= ph;
        ev_v  <= e;
        notes.push_back('{c, f});
        @(posedge clk);
        ev_v <= '0;
        repeat (2) @(posedge clk);
    endtask : fire

    task automatic parse(input logic [7:0] ml, input logic [7:0] cl,
                         input logic [15:0] em, input logic [8:0] md,
                         input logic [16:0] x, input logic [15:0] c);
        mlen <= ml;
        clen <= cl;
        emag <= em;
        mdig <= md;
        fire(RUN, ev(13) | x, c, F_N);
    endtask : parse

    // Monitor: one note per sampled event or key pulse
    always @(posedge clk) took <= |ev_v | pkey;
    always @(negedge clk) begin
        if (took && notes.size() == 0) begin
            chk("note queue", 16'h0001, 16'h0000);
        end else if (took) begin
            n = notes.pop_front();
            m = n.flg[0] ? 8'h9e : 8'hfe;
            chk("err_code_q", n.code, ecq);
            chk("flags", {8'h00, n.flg & m},
                {8'h00, {evq, hq, aq, ldq, lwq, kq, keq, 1'b0} & m});
        end
    end

    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h546e));
        rst_dut();
        fire(RUN, ev(0), 16'h000b, F_HA);
        fire(PON, ev(1), 16'h000c, F_HA);
        fire(SLF, ev(1), 16'h000c, F_A);
        fire(RUN, ev(2), 16'h000d, F_HA);
        fire(RUN, ev(3), 16'h000e, F_HA);
        fire(PON, ev(4), 16'h000f, F_LD);
        fire(SLF, ev(4), 16'h000f, F_A);
        fire(PON, ev(5), 16'h0010, F_N);
        fire(SLF, ev(5), 16'h0010, F_HA);
        fire(RUN, ev(6), 16'h0011, F_N);
        fire(RUN, ev(7), 16'h0012, F_N);
        fire(RUN, ev(8), 16'h0013, F_N);
        fire(PON, ev(9), 16'h0014, F_HA);
        fire(SLF, ev(9), 16'h0014, F_A);
        cause <= 1'b1;
        fire(RUN, ev(6), 16'h000e, F_C);
        fire(RUN, ev(7), 16'h000e, F_C);
        cause <= 1'b0;
        $display("Test instrument faults done");
        leak <= 32'sh00a7d8c0;
        fire(RUN, ev(10), 16'h0020, F_N);
        leak <= -32'sh00a7d8c0;
        fire(RUN, ev(10), 16'h0020, F_N);
        leak <= 32'sh0000000b + 32'($urandom_range(9999978));
        fire(RUN, ev(10), 16'h0000, F_W);
        leak  <= 32'sh0;
        stray <= 32'h000124f8;
        fire(RUN, ev(10), 16'h0021, F_N);
        stray <= 32'h000124f7;
        fire(RUN, ev(10), 16'h0000, 8'h02);
        fire(RUN, ev(11), 16'h0023, F_N);
        fire(RUN, ev(12), 16'h0024, F_N);
        $display("Test correction and fixture done");
        rl = 8'($urandom_range(12, 1));
        parse(8'h0d, rl, 16'h0, 9'h0, '0, 16'hff90);
        parse(rl, 8'h0d, 16'h0, 9'h0, '0, 16'hff70);
        parse(rl, 8'h0c, 16'h7d01, 9'h0, '0, 16'hff85);
        parse(rl, 8'h0c, 16'h7d00, 9'h100, '0, 16'hff84);
        parse(rl, 8'h0c, 16'h0, 9'h0, ev(14), 16'hff97);
        parse(rl, 8'h0c, 16'h0, 9'h0, ev(15), 16'hff94);
        parse(rl, 8'h0c, 16'h0, 9'h0, ev(16), 16'hff93);
        parse(8'h0c, 8'h0c, 16'h7d00, 9'h0ff, '0, 16'hff9c);
        $display("Test parser codes done");
        rst_dut();
        lock_cmd <= 1'b1;
        meas     <= 1'b1;
        clim     <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("range_exceeded_flag_q", 16'h1, {15'h0, rof});
        chk("over_current_q", 16'h1, {15'h0, ocq});
        @(posedge clk);
        meas <= 1'b0;
        clim <= 1'b0;
        notes.push_back('{16'h0015, 8'h80});
        press_cmd <= 1'b1;
        @(posedge clk);
        press_cmd <= 1'b0;
        unl_cmd   <= 1'b1;
        @(posedge clk);
        unl_cmd <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("keys_enabled_q", 16'h0, {15'h0, keq});
        chk("range_exceeded_flag_q", 16'h0, {15'h0, rof});
        chk("over_current_q", 16'h0, {15'h0, ocq});
        @(posedge clk);
        lock_cmd <= 1'b0;
        repeat (3) @(posedge clk);
        notes.push_back('{16'h0015, 8'h86});
        press_cmd <= 1'b1;
        @(posedge clk);
        press_cmd <= 1'b0;
        repeat (4) @(posedge clk);
        chk("notes left", 16'h0, 16'(notes.size()));
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(negedge clk);
        chk("err_valid_q", 16'h0, {15'h0, evq});
        chk("err_code_q", 16'h0, ecq);
        $display("Test lockout and range flags done");
        wrap_up();
    end
endmodule : testbench
